// *** include/sline_defines.svh ***
/*
  Constants of the supply-line programming link: time figures, bit-window
  percentages, command codes, field widths and reply lengths.
  Assumes a 50 MHz system clock; included by the package and the top module.
*/
`ifndef SLINE_DEFINES_SVH
`define SLINE_DEFINES_SVH

// ---------------------------------------------------------------
// clock and times
// ---------------------------------------------------------------
`define SLINE_CLK_MHZ 50
`define SLINE_SYNC_MIN_US 3400
`define SLINE_SYNC_MAX_US 3600
`define SLINE_OUT_BIT_US 4000
`define SLINE_ARM_WINDOW_US 3000
`define SLINE_CNT_W 18

// ---------------------------------------------------------------
// bit window, percent of a bit period
// ---------------------------------------------------------------
`define SLINE_ONE_MIN_PCT 7'd50
`define SLINE_ONE_MAX_PCT 7'd80
`define SLINE_ONE_NOM_PCT 7'd65
`define SLINE_BOUND_PCT 7'd90
`define SLINE_LATE_PCT 7'd125

// ---------------------------------------------------------------
// telegram layout
// ---------------------------------------------------------------
`define SLINE_HDR_BITS 5'd9
`define SLINE_WR_BITS 5'd24
`define SLINE_DATA_W 14
`define SLINE_ADDR_W 4
`define SLINE_ACK_LEN 5'd1
`define SLINE_RD_LEN 5'd16
`define SLINE_ADDR_ADC 4'h7

// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define SLINE_CMD_READ 3'h2
`define SLINE_CMD_WRITE 3'h3
`define SLINE_CMD_PROG 3'h4
`define SLINE_CMD_ERASE 3'h5
`define SLINE_CMD_LOCKI 3'h6
`define SLINE_CMD_LOCK 3'h7

`endif

// *** include/sline_pkg.sv ***
/*
  Types of the supply-line programming link: command codes and receiver states.
  Assumes sline_defines.svh on the include path.
*/
`include "sline_defines.svh"

package sline_pkg;

  typedef enum logic [2:0] {
    CMD_READ = `SLINE_CMD_READ,
    CMD_WRITE = `SLINE_CMD_WRITE,
    CMD_PROG = `SLINE_CMD_PROG,
    CMD_ERASE = `SLINE_CMD_ERASE,
    CMD_LOCKI = `SLINE_CMD_LOCKI,
    CMD_LOCK = `SLINE_CMD_LOCK
  } cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SYNC,
    ST_BITS,
    ST_EXEC,
    ST_RD_WAIT,
    ST_REPLY,
    ST_ARMED,
    ST_PROGRAM
  } state_t;

endpackage

// *** hdl/reg_store.sv ***
/*
  Small register store: one write port, one read port with registered data.
  Assumes both ports on clk_sys; the array itself is not reset.
*/
`timescale 1ns/1ns
`default_nettype none

module reg_store #(
  parameter int DW = 14,
  parameter int AW = 4
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk_sys) begin
    if (clk_en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_data <= '0;
    end else if (clk_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

`default_nettype wire

// *** hdl/supply_line_programming_telegram.sv ***
/*
  Sensor side of the supply-line programming link: decodes telegrams seen as
  a high/low supply level, executes read, write, program, erase and lock
  commands and answers with an edge-coded telegram on the output pin.
  Assumes supply_high and prog_level come from comparators (asynchronous),
  adc_value comes from logic on clk_sys.

*/
`timescale 1ns/1ns
`default_nettype none
`include "sline_defines.svh"

module supply_line_programming_telegram #(
  parameter logic [`SLINE_CNT_W-1:0] SYNC_MIN_CYC = `SLINE_CNT_W'(`SLINE_SYNC_MIN_US * `SLINE_CLK_MHZ),
  parameter logic [`SLINE_CNT_W-1:0] SYNC_MAX_CYC = `SLINE_CNT_W'(`SLINE_SYNC_MAX_US * `SLINE_CLK_MHZ),
  parameter logic [`SLINE_CNT_W-1:0] OUT_BIT_CYC = `SLINE_CNT_W'(`SLINE_OUT_BIT_US * `SLINE_CLK_MHZ),
  parameter logic [`SLINE_CNT_W-1:0] ARM_CYC = `SLINE_CNT_W'(`SLINE_ARM_WINDOW_US * `SLINE_CLK_MHZ)
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic supply_high,
  input wire logic prog_level,
  input wire logic [`SLINE_DATA_W-1:0] adc_value,
  output logic out_level,
  output logic out_drive_en,
  output logic nv_program,
  output logic nv_erase,
  output logic device_locked
);

  localparam int CW = `SLINE_CNT_W;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [CW-1:0] pct(input logic [CW-1:0] p, input logic [6:0] k);
    logic [CW+6:0] w;
    w = (CW+7)'(p) * (CW+7)'(k);
    pct = CW'(w / (CW+7)'(100));
  endfunction

  // one when the vector holds an odd number of zeros; pad with ones
  function automatic logic odd_zeros(input logic [`SLINE_DATA_W-1:0] v);
    odd_zeros = ^(~v);
  endfunction

  // ---------------------------------------------------------------
  // supply level synchroniser and edge
  // ---------------------------------------------------------------
  logic sup_meta, sup_sync, sup_prev, prog_meta, prog_sync, prog_prev;
  logic sup_edge, prog_rise;
  logic [2:0] sync_fill;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sup_meta <= 1'b0;
      sup_sync <= 1'b0;
      sup_prev <= 1'b0;
      prog_meta <= 1'b0;
      prog_sync <= 1'b0;
      prog_prev <= 1'b0;
      sync_fill <= '0;
    end else if (clk_en) begin
      sync_fill <= {sync_fill[1:0], 1'b1};
      sup_meta <= supply_high;
      sup_sync <= sup_meta;
      sup_prev <= sup_sync;
      prog_meta <= prog_level;
      prog_sync <= prog_meta;
      prog_prev <= prog_sync;
    end
  end

  // pin may sit high at release: no edge until the pipeline holds its level
  assign sup_edge = (sup_sync ^ sup_prev) & sync_fill[2];
  assign prog_rise = prog_sync & ~prog_prev & sync_fill[2];

  // ---------------------------------------------------------------
  // receiver and command state
  // ---------------------------------------------------------------
  sline_pkg::state_t state;
  logic [CW-1:0] cnt, period;
  logic mid_seen;
  logic [4:0] bit_idx;
  logic [23:0] shift, next_shift;
  logic [8:0] hdr;
  logic [2:0] cmd;
  logic [3:0] addr;
  logic [`SLINE_DATA_W-1:0] data;
  logic data_par;
  logic hdr_ok, data_ok, is_boundary, is_mid, is_late, last_bit;
  logic arm_erase;
  logic [15:0] tx_bits;
  logic [4:0] tx_left;
  logic wr_en;
  logic [`SLINE_DATA_W-1:0] rd_data;

  assign next_shift = {shift[22:0], mid_seen};
  assign cmd = hdr[8:6];
  assign addr = hdr[4:1];
  assign data = shift[14:1];
  assign data_par = shift[0];
  assign hdr_ok = (hdr[5] == odd_zeros({11'h7FF, cmd}))
    && (hdr[0] == odd_zeros({10'h3FF, addr}));
  assign data_ok = (data_par == ~odd_zeros(data));
  assign is_boundary = cnt >= pct(period, `SLINE_BOUND_PCT);
  assign is_mid = !mid_seen && cnt >= pct(period, `SLINE_ONE_MIN_PCT)
    && cnt <= pct(period, `SLINE_ONE_MAX_PCT);
  assign is_late = cnt > pct(period, `SLINE_LATE_PCT);
  // header fixes the length once the command bits are known
  assign last_bit = (bit_idx + 5'd1 == `SLINE_HDR_BITS && next_shift[8:6] != `SLINE_CMD_WRITE)
    || (bit_idx + 5'd1 == `SLINE_WR_BITS);
  assign wr_en = clk_en && state == sline_pkg::ST_EXEC && hdr_ok && data_ok
    && cmd == sline_pkg::CMD_WRITE && !device_locked;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= sline_pkg::ST_IDLE;
      cnt <= '0;
      period <= '0;
      mid_seen <= 1'b0;
      bit_idx <= '0;
      shift <= '0;
      hdr <= '0;
      tx_bits <= '0;
      tx_left <= '0;
      arm_erase <= 1'b0;
      device_locked <= 1'b0;
    end else if (clk_en) begin
      unique case (state)
        sline_pkg::ST_IDLE: begin
          cnt <= '0;
          // the first supply edge opens the sync bit
          if (sup_edge && !device_locked) begin
            state <= sline_pkg::ST_SYNC;
          end
        end
        sline_pkg::ST_SYNC: begin
          cnt <= cnt + 1'b1;
          if (sup_edge) begin
            cnt <= '0;
            mid_seen <= 1'b0;
            bit_idx <= '0;
            if (cnt >= SYNC_MIN_CYC && cnt <= SYNC_MAX_CYC) begin
              period <= cnt;
              state <= sline_pkg::ST_BITS;
            end else begin
              state <= sline_pkg::ST_IDLE;
            end
          end else if (cnt > SYNC_MAX_CYC) begin
            state <= sline_pkg::ST_IDLE;
          end
        end
        sline_pkg::ST_BITS: begin
          cnt <= cnt + 1'b1;
          if (sup_edge && is_boundary) begin
            cnt <= '0;
            mid_seen <= 1'b0;
            shift <= next_shift;
            bit_idx <= bit_idx + 5'd1;
            if (bit_idx + 5'd1 == `SLINE_HDR_BITS) begin
              hdr <= next_shift[8:0];
            end
            if (last_bit) begin
              state <= sline_pkg::ST_EXEC;
            end
          end else if (sup_edge && is_mid) begin
            mid_seen <= 1'b1;
          end else if (sup_edge || is_late) begin
            state <= sline_pkg::ST_IDLE;
          end
        end
        sline_pkg::ST_EXEC: begin
          cnt <= '0;
          tx_bits <= '0;
          tx_left <= `SLINE_ACK_LEN;
          arm_erase <= cmd == sline_pkg::CMD_ERASE;
          state <= sline_pkg::ST_REPLY;
          if (!hdr_ok) begin
            state <= sline_pkg::ST_IDLE;
          end else begin
            unique case (cmd)
              sline_pkg::CMD_READ: state <= sline_pkg::ST_RD_WAIT;
              sline_pkg::CMD_WRITE: begin
                if (!data_ok) begin
                  state <= sline_pkg::ST_IDLE;
                end
              end
              sline_pkg::CMD_PROG, sline_pkg::CMD_ERASE, sline_pkg::CMD_LOCKI: begin
              end
              sline_pkg::CMD_LOCK: device_locked <= 1'b1;
              default: state <= sline_pkg::ST_IDLE;
            endcase
          end
        end
        sline_pkg::ST_RD_WAIT: begin
          // acknowledge zero, data, then its parity
          if (addr == `SLINE_ADDR_ADC) begin
            tx_bits <= {1'b0, adc_value, ~odd_zeros(adc_value)};
          end else begin
            tx_bits <= {1'b0, rd_data, ~odd_zeros(rd_data)};
          end
          tx_left <= `SLINE_RD_LEN;
          state <= sline_pkg::ST_REPLY;
        end
        sline_pkg::ST_REPLY: begin
          cnt <= cnt + 1'b1;
          if (cnt == OUT_BIT_CYC - 1'b1) begin
            cnt <= '0;
            tx_bits <= {tx_bits[14:0], 1'b0};
            tx_left <= tx_left - 5'd1;
            if (tx_left == 5'd1) begin
              state <= (cmd == sline_pkg::CMD_PROG || cmd == sline_pkg::CMD_ERASE)
                ? sline_pkg::ST_ARMED : sline_pkg::ST_IDLE;
            end
          end
        end
        sline_pkg::ST_ARMED: begin
          // programmer raises the supply after its delay; give up otherwise
          cnt <= cnt + 1'b1;
          if (prog_rise) begin
            state <= sline_pkg::ST_PROGRAM;
          end else if (cnt >= ARM_CYC) begin
            state <= sline_pkg::ST_IDLE;
          end
        end
        sline_pkg::ST_PROGRAM: begin
          // programming lasts while the programmer holds the level
          if (!prog_sync) begin
            state <= sline_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // output pin coding
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      out_level <= 1'b0;
      out_drive_en <= 1'b0;
    end else if (clk_en) begin
      out_drive_en <= state == sline_pkg::ST_REPLY;
      // opening edge marks the start of the acknowledge bit
      if ((state == sline_pkg::ST_EXEC && hdr_ok && cmd != sline_pkg::CMD_READ
          && (cmd != sline_pkg::CMD_WRITE || data_ok) && cmd > 3'h1)
          || state == sline_pkg::ST_RD_WAIT) begin
        out_level <= ~out_level;
      end else if (state == sline_pkg::ST_REPLY) begin
        if (cnt == pct(OUT_BIT_CYC, `SLINE_ONE_NOM_PCT) && tx_bits[15]) begin
          out_level <= ~out_level;
        end else if (cnt == OUT_BIT_CYC - 1'b1) begin
          out_level <= ~out_level;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // nonvolatile strobes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      nv_program <= 1'b0;
      nv_erase <= 1'b0;
    end else if (clk_en) begin
      nv_program <= (state == sline_pkg::ST_PROGRAM || (state == sline_pkg::ST_ARMED
        && prog_rise)) && prog_sync && !arm_erase;
      nv_erase <= (state == sline_pkg::ST_PROGRAM || (state == sline_pkg::ST_ARMED
        && prog_rise)) && prog_sync && arm_erase;
    end
  end

  reg_store #(
    .DW(`SLINE_DATA_W),
    .AW(`SLINE_ADDR_W)
  ) u_store (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clk_en(clk_en),
    .wr_en(wr_en),
    .wr_addr(addr),
    .wr_data(data),
    .rd_addr(addr),
    .rd_data(rd_data)
  );

endmodule

`default_nettype wire

// *** test/sline_chk.sv ***
/*
  Checker of the telegram block: reply edges, programming flags, lock.
  Assumes only the top module's ports, all on clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sline_defines.svh"

module sline_chk #(
  parameter logic [`SLINE_CNT_W-1:0] OUT_BIT_CYC = `SLINE_CNT_W'(400)
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic supply_high,
  input wire logic prog_level,
  input wire logic [`SLINE_DATA_W-1:0] adc_value,
  input wire logic out_level,
  input wire logic out_drive_en,
  input wire logic nv_program,
  input wire logic nv_erase,
  input wire logic device_locked
);
  localparam int BIT = int'(OUT_BIT_CYC);
  // the mid edge lands one cycle after the counter reaches 65 percent
  localparam int ONE = BIT * 65 / 100 + 1;
  int gap;
  int sup_gap;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  // cycles since the last change of pin and supply
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gap <= 0;
      sup_gap <= 0;
    end else begin
      gap <= $changed(out_level) ? 1 : gap + 1;
      sup_gap <= $changed(supply_high) ? 1 : sup_gap + 1;
    end
  end

  sequence seq_quiet;
    !$changed(out_level) [*8];
  endsequence
  sequence seq_clear;
    ##[1:5] (!nv_program && !nv_erase);
  endsequence

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  open_toggle_a: assert property (
    $rose(out_drive_en) |-> $past(out_level) != $past(out_level, 2))
    else $error("reply began without opening toggle");
  quiet_pin_a: assert property (
    $changed(out_level) |-> (out_drive_en || $past(out_drive_en)) or (##1 out_drive_en))
    else $error("pin changed outside a reply");
  bit_edges_a: assert property (
    out_drive_en && $changed(out_level) |-> gap == BIT || gap == ONE || gap == BIT - ONE)
    else $error("reply edge off its bit grid");
  bit_quiet_a: assert property (
    out_drive_en && $changed(out_level) |=> seq_quiet)
    else $error("reply edges too close");
  reply_start_a: assert property (
    $rose(out_drive_en) |-> sup_gap >= 3 && sup_gap <= 10)
    else $error("reply not right after the telegram");
  prog_follow_a: assert property (
    $rose(nv_program) || $rose(nv_erase) |-> prog_level && !out_drive_en)
    else $error("programming without programming level");
  prog_release_a: assert property (
    $fell(prog_level) |-> seq_clear)
    else $error("programming flag stayed after level fell");
  one_flag_a: assert property (
    !(nv_program && nv_erase))
    else $error("program and erase together");
  lock_sticky_a: assert property (
    $past(device_locked) |-> device_locked)
    else $error("lock flag cleared");
endmodule

bind supply_line_programming_telegram sline_chk #(.OUT_BIT_CYC(OUT_BIT_CYC)) chk (
  .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .supply_high(supply_high),
  .prog_level(prog_level), .adc_value(adc_value), .out_level(out_level),
  .out_drive_en(out_drive_en), .nv_program(nv_program), .nv_erase(nv_erase),
  .device_locked(device_locked));

`default_nettype wire

// *** test/programmer_model.sv ***
/*
  Programmer model: edge-coded telegrams as supply levels, programming level.
  Assumes its tasks are called at a falling clock edge.
*/
`timescale 1ns/1ns
`default_nettype none

module programmer_model (
  input wire logic clk_sys,
  output logic supply_high,
  output logic prog_level
);
  initial begin
    supply_high = 1'b0;
    prog_level = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // zero sync bit, then n bits msb first
  task automatic send(input logic [23:0] b, input int n, input int per);
    int i;
    supply_high = ~supply_high;
    hold(per);
    for (i = n - 1; i >= 0; i--) begin
      supply_high = ~supply_high;
      if (b[i]) begin
        hold(per * 65 / 100);
        supply_high = ~supply_high;
        hold(per - per * 65 / 100);
      end else begin
        hold(per);
      end
    end
    supply_high = ~supply_high;
  endtask

  task automatic pulse(input int dly, input int len);
    hold(dly);
    prog_level = 1'b1;
    hold(len);
    prog_level = 1'b0;
  endtask
endmodule

`default_nettype wire

// *** test/supply_line_programming_telegram_bench.sv ***
/*
  Bench of the telegram block: telegrams through the programmer model,
  replies decoded on the pin against a queue of notes.
  Assumes shortened timing parameters; clock enable held high.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sline_defines.svh"

module supply_line_programming_telegram_bench;
  localparam int BIT = 80;
  localparam logic [2:0] R = sline_pkg::CMD_READ;
  localparam logic [2:0] W = sline_pkg::CMD_WRITE;
  logic clk_sys, rstn, supply_high, prog_level, out_level, out_drive_en;
  logic nv_program, nv_erase, device_locked;
  logic [`SLINE_DATA_W-1:0] adc_value;
  logic [20:0] exp_q[$];
  logic [15:0] rnd;
  int err_count, samples_checked;

  programmer_model prog (.clk_sys(clk_sys), .supply_high(supply_high),
    .prog_level(prog_level));
  supply_line_programming_telegram #(.SYNC_MIN_CYC(`SLINE_CNT_W'(68)),
    .SYNC_MAX_CYC(`SLINE_CNT_W'(72)), .OUT_BIT_CYC(`SLINE_CNT_W'(BIT)),
    .ARM_CYC(`SLINE_CNT_W'(60))) dut (.clk_sys(clk_sys), .rstn(rstn),
    .clk_en(1'b1), .supply_high(supply_high), .prog_level(prog_level),
    .adc_value(adc_value), .out_level(out_level), .out_drive_en(out_drive_en),
    .nv_program(nv_program), .nv_erase(nv_erase), .device_locked(device_locked));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [8:0] hdr(input logic [2:0] c, input logic [3:0] a);
    return {c, ~(^c), a, ^a};
  endfunction

  task automatic check(input logic [20:0] got, input logic [20:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // send, note the reply of rn bits, or check that none came
  task automatic tele(input logic [23:0] b, input int n, input int per,
    input int rn, input logic [15:0] rw);
    int t;
    if (rn > 0) exp_q.push_back({5'(rn), rw});
    prog.send(b, n, per);
    for (t = 0; t < 3000 && exp_q.size() > 0; t++) @(negedge clk_sys);
    repeat (rn > 0 ? 2 : 3 * BIT) @(negedge clk_sys);
    if (rn == 0) check({20'h0, out_drive_en}, 21'h0);
    $display("telegram done at %0t", $time);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    #1600000;
    err_count++;
    complete_run();
  end

  // decode replies: ack length sets the bit period
  initial begin : watch
    logic prv, en, mid;
    logic [15:0] w;
    logic [4:0] n;
    int cnt, p, st;
    prv = 1'b0; en = 1'b0; mid = 1'b0; w = 16'h0; n = 5'h0; cnt = 0; p = 0; st = 0;
    forever begin
      @(negedge clk_sys);
      cnt++;
      if (out_level !== prv) begin
        if (st != 0 && st != 1 && cnt < p * 9 / 10) begin
          mid = 1'b1;
        end else begin
          if (st == 1) p = cnt;
          if (st != 0) w = {w[14:0], mid};
          if (st != 0) n++;
          st = st == 0 ? 1 : 2;
          mid = 1'b0;
          cnt = 0;
        end
      end
      prv = out_level;
      if (en && out_drive_en !== 1'b1) begin
        if (exp_q.size() == 0) check({n, w}, 21'h0);
        else check({n, w}, exp_q.pop_front());
        check(21'(p), 21'(BIT));
        st = 0; n = 5'h0; w = 16'h0;
      end
      en = out_drive_en === 1'b1;
      if (rstn !== 1'b1) st = 0;
    end
  end

  initial begin : main
    logic [13:0] mem [4];
    int i;
    rstn = 1'b0; adc_value = 14'h0000; rnd = 16'h0059; err_count = 0; samples_checked = 0;
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    for (i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      mem[i] = rnd[13:0];
      tele({hdr(W, 4'(i)), mem[i], ~(^mem[i])}, 24, 69 + i % 3, 1, 16'h0);
      tele({15'h0, hdr(R, 4'(i))}, 9, 71 - i % 3, 16, {1'b0, mem[i], ~(^mem[i])});
    end
    rnd = lfsr(rnd);
    adc_value = rnd[13:0];
    tele({15'h0, hdr(R, 4'h7)}, 9, 70, 16, {1'b0, adc_value, ~(^adc_value)});
    tele({15'h0, hdr(R, 4'h1) ^ 9'h020}, 9, 70, 0, 16'h0);
    tele({15'h0, hdr(R, 4'h1) ^ 9'h001}, 9, 70, 0, 16'h0);
    tele({15'h0, hdr(3'h0, 4'h1)}, 9, 70, 0, 16'h0);
    tele({15'h0, hdr(3'h1, 4'h1)}, 9, 70, 0, 16'h0);
    tele({hdr(W, 4'h1), ~mem[1], ^mem[1]}, 24, 70, 0, 16'h0);
    tele({15'h0, hdr(R, 4'h1)}, 9, 70, 16, {1'b0, mem[1], ~(^mem[1])});
    tele({15'h0, hdr(R, 4'h1)}, 9, 60, 0, 16'h0);
    tele({15'h0, hdr(R, 4'h1)}, 9, 80, 0, 16'h0);
    // reset in mid-run realigns the receiver after the timing faults
    rstn = 1'b0;
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    for (i = 4; i < 6; i++) begin
      tele({15'h0, hdr(3'(i), 4'h0)}, 9, 70, 1, 16'h0);
      fork
        prog.pulse(20, 40);
        begin
          repeat (40) @(negedge clk_sys);
          check({19'h0, nv_program, nv_erase}, 21'(i == 4 ? 2 : 1));
        end
      join
      repeat (10) @(negedge clk_sys);
      check({19'h0, nv_program, nv_erase}, 21'h0);
      repeat (BIT) @(negedge clk_sys);
    end
    tele({15'h0, hdr(3'h6, 4'h0)}, 9, 70, 1, 16'h0);
    tele({15'h0, hdr(3'h7, 4'h0)}, 9, 70, 1, 16'h0);
    check({20'h0, device_locked}, 21'h1);
    tele({15'h0, hdr(R, 4'h1)}, 9, 70, 0, 16'h0);
    complete_run();
  end
endmodule

`default_nettype wire
